/* hdl/fir_rate_cfg.svh */
`ifndef FIR_RATE_CFG_SVH
`define FIR_RATE_CFG_SVH
// register byte offsets
`define OFS_MODE 8'h00
`define OFS_CODE 8'h04
`define OFS_FINE 8'h08
`define OFS_CYCLE 8'h0C
`define OFS_STATUS 8'h10
// reset values
`define MODE_RESET 16'h0000
`define CODE_RESET 8'h00
`define FINE_RESET 16'h0000
`define CYCLE_RESET 8'h00
// status bit positions
`define STAT_ADC_INVALID 0
`define STAT_FIR_NOT_READY 5
// mode values and code limits
`define MODE_SELECTABLE 16'h0000
`define MODE_FINE 16'h0001
`define CODE_FIRST_INVALID 4'hE
// timing
`define CLK_MHZ 10
`define IO_FAST_US 50
`define IO_SLOW_US 100
`define IO_FAST_CYC (`IO_FAST_US * `CLK_MHZ)
`define IO_SLOW_CYC (`IO_SLOW_US * `CLK_MHZ)
// clock rate in tenths of hertz, the wrap point of the rate accumulator
`define RATE_ACC_LIMIT 28'h5F5_E100
`define SETTLE_STROBES 4
`endif

/* hdl/fir_rate_pkg.sv */
package fir_rate_pkg;
   typedef enum logic [1:0] {
      WR_IDLE = 2'b01,
      WR_RESP = 2'b10
   } wr_state_t;
   typedef enum logic [1:0] {
      RD_IDLE = 2'b01,
      RD_DATA = 2'b10
   } rd_state_t;
endpackage

/* hdl/rate_strobe_gen.sv */
`timescale 1ns/1ns
`include "fir_rate_cfg.svh"
// phase accumulator: one tick per output sample at rate_i tenths of hertz
module rate_strobe_gen #(
   parameter int ACC_W = 28,
   parameter int RATE_W = 17,
   parameter logic [27:0] LIMIT = `RATE_ACC_LIMIT
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // control
   input wire logic enable_i,
   input wire logic restart_i,
   input wire logic [RATE_W-1:0] rate_i,
   // tick out
   output logic tick_o
);
   logic [ACC_W-1:0] acc_r;
   logic [ACC_W-1:0] sum;
   assign sum = acc_r + ACC_W'(rate_i);
   // restart aligns the first sample to the new setting
   always_ff @(posedge clk_i) begin
      if (reset_i || restart_i || !enable_i) begin
         acc_r <= '0;
         tick_o <= 1'b0;
      end else if (sum >= ACC_W'(LIMIT)) begin
         acc_r <= sum - ACC_W'(LIMIT);
         tick_o <= 1'b1;
      end else begin
         acc_r <= sum;
         tick_o <= 1'b0;
      end
   end
endmodule

/* hdl/fir_output_rate_config.sv */
`timescale 1ns/1ns
`include "fir_rate_cfg.svh"
// Behaviour
// - With the mode register at 0, its reset value, the filter runs at the fixed coded rate.
// - With the mode register at 1, the filter runs at the fine rate register value instead.
// - Code bits 0-3 map 0..13 onto 2.5 to 7500 samples per second; bits 4-7 are written 0.
// - Codes 14 and 15 mark the input value as an invalid range instead of a measurement.
// - In fine mode a fine rate of zero switches the filter off.
// - In fine mode values 1 to 65535 give a linear rate of 0.1 Hz per step.
// - In multiple sampling the io update comes every 50 or 100 us per the cycle setting.
// - Cycle setting 0, the default, means 50 us and 1 means 100 us; 2 to 255 are reserved.
// - Status bit 5 stays set until the filter has settled and clears once output is ready.
module fir_output_rate_config
   import fir_rate_pkg::*;
#(
   parameter int SETTLE = `SETTLE_STROBES
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // axi4-lite write address and data
   input wire logic awvalid_i,
   output logic awready_o,
   input wire logic [7:0] awaddr_i,
   input wire logic wvalid_i,
   output logic wready_o,
   input wire logic [31:0] wdata_i,
   input wire logic [3:0] wstrb_i,
   // axi4-lite write response
   output logic bvalid_o,
   input wire logic bready_i,
   output logic [1:0] bresp_o,
   // axi4-lite read
   input wire logic arvalid_i,
   output logic arready_o,
   input wire logic [7:0] araddr_i,
   output logic rvalid_o,
   input wire logic rready_i,
   output logic [31:0] rdata_o,
   output logic [1:0] rresp_o,
   // function model select from the same clock domain
   input wire logic multisample_i,
   // filter control out
   output logic fir_enable_o,
   output logic fir_strobe_o,
   output logic [16:0] fir_rate_tenths_o,
   output logic invalid_range_o,
   output logic fir_not_ready_o,
   output logic io_update_o
);
   wr_state_t wr_state_r;
   rd_state_t rd_state_r;
   logic aw_got_r, w_got_r, aw_hs, w_hs, do_write, cfg_change;
   logic [7:0] awaddr_r, wr_addr;
   logic [31:0] wdata_r, wr_data;
   logic [3:0] wstrb_r, wr_strb;
   logic [15:0] mode_r, fine_r;
   logic [7:0] code_r, cycle_r;
   logic [16:0] rate_nxt;
   logic enable_nxt, invalid_nxt, tick, wr_mapped;
   logic [$clog2(SETTLE+1)-1:0] settle_cnt_r;
   logic [9:0] io_cnt_r, io_period;
   logic [31:0] rd_mux;

   // fixed rate table in tenths of hertz
   function automatic logic [16:0] code_rate(input logic [3:0] c);
      case (c)
         4'h0: code_rate = 17'h0_0019;
         4'h1: code_rate = 17'h0_0032;
         4'h2: code_rate = 17'h0_0064;
         4'h3: code_rate = 17'h0_0096;
         4'h4: code_rate = 17'h0_00FA;
         4'h5: code_rate = 17'h0_012C;
         4'h6: code_rate = 17'h0_01F4;
         4'h7: code_rate = 17'h0_0258;
         4'h8: code_rate = 17'h0_03E8;
         4'h9: code_rate = 17'h0_1388;
         4'hA: code_rate = 17'h0_2710;
         4'hB: code_rate = 17'h0_4E20;
         4'hC: code_rate = 17'h0_927C;
         4'hD: code_rate = 17'h1_24F8;
         default: code_rate = 17'h0_0000;
      endcase
   endfunction

   // write side: address and data accepted in either order
   assign aw_hs = awvalid_i && awready_o;
   assign w_hs = wvalid_i && wready_o;
   assign wr_addr = aw_got_r ? awaddr_r : awaddr_i;
   assign wr_data = w_got_r ? wdata_r : wdata_i;
   assign wr_strb = w_got_r ? wstrb_r : wstrb_i;
   assign do_write = (wr_state_r == WR_IDLE) && (aw_got_r || aw_hs) && (w_got_r || w_hs);
   assign wr_mapped = (wr_addr == `OFS_MODE) || (wr_addr == `OFS_CODE) ||
                      (wr_addr == `OFS_FINE) || (wr_addr == `OFS_CYCLE);
   assign cfg_change = do_write && ((wr_addr == `OFS_MODE) || (wr_addr == `OFS_CODE) ||
                                    (wr_addr == `OFS_FINE));

   // write channel handshake
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         wr_state_r <= WR_IDLE;
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         awready_o <= 1'b1;
         wready_o <= 1'b1;
         bvalid_o <= 1'b0;
         bresp_o <= 2'b00;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
      end else begin
         case (wr_state_r)
            WR_IDLE: begin
               if (aw_hs) begin
                  aw_got_r <= 1'b1;
                  awaddr_r <= awaddr_i;
                  awready_o <= 1'b0;
               end
               if (w_hs) begin
                  w_got_r <= 1'b1;
                  wdata_r <= wdata_i;
                  wstrb_r <= wstrb_i;
                  wready_o <= 1'b0;
               end
               if (do_write) begin
                  wr_state_r <= WR_RESP;
                  awready_o <= 1'b0;
                  wready_o <= 1'b0;
                  bvalid_o <= 1'b1;
                  bresp_o <= wr_mapped ? 2'b00 : 2'b10;
               end
            end
            WR_RESP: begin
               if (bready_i) begin
                  wr_state_r <= WR_IDLE;
                  bvalid_o <= 1'b0;
                  aw_got_r <= 1'b0;
                  w_got_r <= 1'b0;
                  awready_o <= 1'b1;
                  wready_o <= 1'b1;
               end
            end
            default: wr_state_r <= WR_IDLE;
         endcase
      end
   end

   // configuration registers with byte enables
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         mode_r <= `MODE_RESET;
         code_r <= `CODE_RESET;
         fine_r <= `FINE_RESET;
         cycle_r <= `CYCLE_RESET;
      end else if (do_write) begin
         case (wr_addr)
            `OFS_MODE: begin
               if (wr_strb[0]) mode_r[7:0] <= wr_data[7:0];
               if (wr_strb[1]) mode_r[15:8] <= wr_data[15:8];
            end
            `OFS_CODE: if (wr_strb[0]) code_r <= wr_data[7:0];
            `OFS_FINE: begin
               if (wr_strb[0]) fine_r[7:0] <= wr_data[7:0];
               if (wr_strb[1]) fine_r[15:8] <= wr_data[15:8];
            end
            `OFS_CYCLE: if (wr_strb[0]) cycle_r <= wr_data[7:0];
            default: ;
         endcase
      end
   end

   // read mux; reserved bits read zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (araddr_i)
         `OFS_MODE: rd_mux[15:0] = mode_r;
         `OFS_CODE: rd_mux[7:0] = code_r;
         `OFS_FINE: rd_mux[15:0] = fine_r;
         `OFS_CYCLE: rd_mux[7:0] = cycle_r;
         `OFS_STATUS: begin
            rd_mux[`STAT_ADC_INVALID] = invalid_range_o;
            rd_mux[`STAT_FIR_NOT_READY] = fir_not_ready_o;
         end
         default: ;
      endcase
   end

   // read channel
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         rd_state_r <= RD_IDLE;
         arready_o <= 1'b1;
         rvalid_o <= 1'b0;
         rdata_o <= 32'h0000_0000;
         rresp_o <= 2'b00;
      end else begin
         case (rd_state_r)
            RD_IDLE: begin
               if (arvalid_i) begin
                  rd_state_r <= RD_DATA;
                  arready_o <= 1'b0;
                  rvalid_o <= 1'b1;
                  rdata_o <= rd_mux;
                  rresp_o <= (araddr_i > `OFS_STATUS || araddr_i[1:0] != 2'b00) ?
                             2'b10 : 2'b00;
               end
            end
            RD_DATA: begin
               if (rready_i) begin
                  rd_state_r <= RD_IDLE;
                  rvalid_o <= 1'b0;
                  arready_o <= 1'b1;
               end
            end
            default: rd_state_r <= RD_IDLE;
         endcase
      end
   end

   // rate selection; only code bits 0-3 are decoded, other modes fall to fine
   always_comb begin
      if (mode_r == `MODE_SELECTABLE) begin
         rate_nxt = code_rate(code_r[3:0]);
         invalid_nxt = code_r[3:0] >= `CODE_FIRST_INVALID;
         enable_nxt = !invalid_nxt;
      end else begin
         rate_nxt = {1'b0, fine_r};
         invalid_nxt = 1'b0;
         enable_nxt = fine_r != 16'h0000;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         fir_rate_tenths_o <= 17'h0_0000;
         fir_enable_o <= 1'b0;
         invalid_range_o <= 1'b0;
         fir_strobe_o <= 1'b0;
      end else begin
         fir_rate_tenths_o <= rate_nxt;
         fir_enable_o <= enable_nxt;
         invalid_range_o <= invalid_nxt;
         fir_strobe_o <= tick;
      end
   end

   // one accumulator step of 0.1 Hz per rate unit
   rate_strobe_gen #(
      .ACC_W(28),
      .RATE_W(17),
      .LIMIT(`RATE_ACC_LIMIT)
   ) u_gen (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .enable_i(fir_enable_o),
      .restart_i(cfg_change),
      .rate_i(fir_rate_tenths_o),
      .tick_o(tick)
   );

   // settling: a new setting wins over the last settling sample
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         fir_not_ready_o <= 1'b1;
         settle_cnt_r <= '0;
      end else if (cfg_change || !fir_enable_o) begin
         fir_not_ready_o <= 1'b1;
         settle_cnt_r <= '0;
      end else if (tick && fir_not_ready_o) begin
         settle_cnt_r <= settle_cnt_r + 1'b1;
         if (settle_cnt_r == ($bits(settle_cnt_r))'(SETTLE - 1)) fir_not_ready_o <= 1'b0;
      end
   end

   // io update pulse; reserved cycle settings run the 50 us default
   assign io_period = (cycle_r == 8'h01) ? 10'(`IO_SLOW_CYC) : 10'(`IO_FAST_CYC);
   always_ff @(posedge clk_i) begin
      if (reset_i || !multisample_i) begin
         io_cnt_r <= 10'h000;
         io_update_o <= 1'b0;
      end else if (io_cnt_r >= io_period - 10'h001) begin
         io_cnt_r <= 10'h000;
         io_update_o <= 1'b1;
      end else begin
         io_cnt_r <= io_cnt_r + 10'h001;
         io_update_o <= 1'b0;
      end
   end

   // checks
   logic [10:0] io_gap_r;
   // 7ff marks a period not to be judged: first after start, or cut by a cycle setting write
   always_ff @(posedge clk_i) begin
      if (reset_i || !multisample_i || (do_write && wr_addr == `OFS_CYCLE)) io_gap_r <= 11'h7FF;
      else if (io_update_o) io_gap_r <= 11'h000;
      else if (io_gap_r != 11'h7FF) io_gap_r <= io_gap_r + 11'h001;
   end
   sequence s_cfg_write;
      cfg_change ##1 fir_not_ready_o;
   endsequence
   sequence s_quiet8;
      !fir_strobe_o [*8];
   endsequence

   a_mode_fixed: assert property (@(posedge clk_i) disable iff (reset_i)
      mode_r == 16'h0000 |=> fir_rate_tenths_o == code_rate($past(code_r[3:0])))
      else $error("fixed mode rate wrong");
   a_mode_fine: assert property (@(posedge clk_i) disable iff (reset_i)
      mode_r == 16'h0001 |=> fir_rate_tenths_o == {1'b0, $past(fine_r)})
      else $error("fine mode rate wrong");
   a_code_top: assert property (@(posedge clk_i) disable iff (reset_i)
      mode_r == 16'h0000 && code_r[3:0] == 4'hD |=> fir_rate_tenths_o == 17'h1_24F8)
      else $error("code 13 not 7500");
   a_code_invalid: assert property (@(posedge clk_i) disable iff (reset_i)
      mode_r == 16'h0000 && code_r[3:0] >= 4'hE |=> invalid_range_o && !fir_enable_o)
      else $error("invalid code not flagged");
   a_fine_off: assert property (@(posedge clk_i) disable iff (reset_i)
      mode_r == 16'h0001 && fine_r == 16'h0000 |=> !fir_enable_o ##1 s_quiet8)
      else $error("zero fine rate left filter on");
   a_strobe_gap: assert property (@(posedge clk_i) disable iff (reset_i)
      fir_strobe_o && fir_rate_tenths_o <= 17'h1_24F8 |=> s_quiet8)
      else $error("strobes too close");
   a_io_period: assert property (@(posedge clk_i) disable iff (reset_i)
      io_update_o && io_gap_r != 11'h7FF |-> io_gap_r == 11'(io_period) - 11'h001)
      else $error("io update period wrong");
   a_cycle_decode: assert property (@(posedge clk_i) disable iff (reset_i)
      cycle_r != 8'h01 |-> io_period == 10'h1F4)
      else $error("cycle setting decode wrong");
   a_settle_set: assert property (@(posedge clk_i) disable iff (reset_i)
      cfg_change |-> s_cfg_write)
      else $error("not ready not set on change");
   a_ready_clear: assert property (@(posedge clk_i) disable iff (reset_i)
      $fell(fir_not_ready_o) |-> $past(tick) && fir_enable_o)
      else $error("ready without a sample");
endmodule

/* bench/bus_master_model.sv */
`timescale 1ns/1ns
// axi4-lite master standing in for the fieldbus master
module bus_master_model #(
   parameter int GAP = 2500
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // command side
   input wire logic go_i,
   input wire logic wr_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] data_i,
   output logic done_o,
   output logic [31:0] rdata_o,
   output logic [1:0] resp_o,
   // axi4-lite side
   output logic awvalid_o,
   input wire logic awready_i,
   output logic [7:0] awaddr_o,
   output logic wvalid_o,
   input wire logic wready_i,
   output logic [31:0] wdata_o,
   output logic [3:0] wstrb_o,
   output logic bready_o,
   input wire logic bvalid_i,
   input wire logic [1:0] bresp_i,
   output logic arvalid_o,
   input wire logic arready_i,
   output logic [7:0] araddr_o,
   output logic rready_o,
   input wire logic rvalid_i,
   input wire logic [31:0] rdata_i,
   input wire logic [1:0] rresp_i
);
   logic busy_r;
   int gap_r;
   // one transfer at a time; done_o blocks a restart on a stale go
   always_ff @(posedge clk_i) begin
      done_o <= 1'b0;
      if (gap_r != 0) gap_r <= gap_r - 1;
      if (reset_i) begin
         {busy_r, awvalid_o, wvalid_o, bready_o, arvalid_o, rready_o} <= '0;
         wstrb_o <= 4'hF;
         gap_r <= 0;
      end else if (!busy_r && go_i && !done_o && (!wr_i || gap_r == 0)) begin
         busy_r <= 1'b1;
         {awvalid_o, wvalid_o, bready_o} <= {3{wr_i}};
         {arvalid_o, rready_o} <= {2{!wr_i}};
         awaddr_o <= addr_i;
         araddr_o <= addr_i;
         wdata_o <= data_i;
      end else begin
         // released lines toggle so a stale value is never mistaken for a live one
         if (!awvalid_o || awready_i) begin
            awvalid_o <= 1'b0;
            awaddr_o <= ~awaddr_o;
         end
         if (!wvalid_o || wready_i) begin
            wvalid_o <= 1'b0;
            wdata_o <= ~wdata_o;
         end
         if (!arvalid_o || arready_i) begin
            arvalid_o <= 1'b0;
            araddr_o <= ~araddr_o;
         end
         if (bvalid_i && bready_o) begin
            {bready_o, busy_r, done_o} <= 3'b001;
            resp_o <= bresp_i;
            gap_r <= GAP;
         end
         if (rvalid_i && rready_o) begin
            {rready_o, busy_r, done_o} <= 3'b001;
            resp_o <= rresp_i;
            rdata_o <= rdata_i;
         end
      end
   end
endmodule

/* bench/fir_output_rate_config_tb.sv */
`timescale 1ns/1ns
`include "fir_rate_cfg.svh"
module fir_output_rate_config_tb;
   logic clk_i = 0, reset_i = 1, multisample_i = 0, go = 0, wr = 0;
   logic [7:0] addr = 0, awaddr, araddr;
   logic [31:0] wdata = 0, rdata, rd, awdata, axrdata;
   logic [1:0] resp, bresp, rresp;
   logic done, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, en, stb, inv, nrdy, iou;
   logic [3:0] wstrb;
   logic [16:0] rate;
   int bad_count = 0, n_compared = 0, cyc = 0, len;
   int code_rate [14] = '{25, 50, 100, 150, 250, 300, 500, 600, 1000, 5000, 10000, 20000,
      37500, 75000};
   // 10 mhz clock
   always #50 clk_i = ~clk_i;
   fir_output_rate_config #(.SETTLE(2)) dut_u (.clk_i(clk_i), .reset_i(reset_i),
      .awvalid_i(awvalid), .awready_o(awready), .awaddr_i(awaddr), .wvalid_i(wvalid),
      .wready_o(wready), .wdata_i(awdata), .wstrb_i(wstrb), .bvalid_o(bvalid),
      .bready_i(bready), .bresp_o(bresp), .arvalid_i(arvalid), .arready_o(arready),
      .araddr_i(araddr), .rvalid_o(rvalid), .rready_i(rready), .rdata_o(axrdata),
      .rresp_o(rresp), .multisample_i(multisample_i), .fir_enable_o(en), .fir_strobe_o(stb),
      .fir_rate_tenths_o(rate), .invalid_range_o(inv), .fir_not_ready_o(nrdy),
      .io_update_o(iou));
   bus_master_model #(.GAP(2500)) master_u (.clk_i(clk_i), .reset_i(reset_i), .go_i(go),
      .wr_i(wr), .addr_i(addr), .data_i(wdata), .done_o(done), .rdata_o(rdata),
      .resp_o(resp), .awvalid_o(awvalid), .awready_i(awready), .awaddr_o(awaddr),
      .wvalid_o(wvalid), .wready_i(wready), .wdata_o(awdata), .wstrb_o(wstrb),
      .bready_o(bready), .bvalid_i(bvalid), .bresp_i(bresp), .arvalid_o(arvalid),
      .arready_i(arready), .araddr_o(araddr), .rready_o(rready), .rvalid_i(rvalid),
      .rdata_i(axrdata), .rresp_i(rresp));
   task report_and_stop;
      $display("mismatches %0d compared %0d", bad_count, n_compared);
      if (bad_count == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %0h seen %0h", name, exp, got);
      end
   endtask
   // one bus transfer through the master, then two cycles for outputs to settle
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      {go, wr, addr, wdata} <= {1'b1, w, a, d};
      do @(posedge clk_i); while (done !== 1'b1);
      go <= 1'b0;
      rd = rdata;
      repeat (2) @(posedge clk_i);
   endtask
   // cycles between two pulses; 3000 means none came
   task span(input bit io);
      int k;
      k = 0;
      while ((io ? iou : stb) !== 1'b1 && k < 3000) begin
         @(posedge clk_i);
         k++;
      end
      len = 0;
      do begin
         @(posedge clk_i);
         len++;
      end while ((io ? iou : stb) !== 1'b1 && len < 3000);
   endtask
   task t_reset;
      check_val("rate", 25, 32'(rate));
      check_val("enable", 1, 32'(en));
      check_val("not ready", 1, 32'(nrdy));
      for (int a = 0; a < 4; a++) begin
         bus(0, 8'(a * 4), 0);
         check_val("reset value", 0, rd);
         check_val("read resp", 0, 32'(resp));
      end
      bus(0, 8'h14, 0);
      check_val("unmapped resp", 2, 32'(resp));
      bus(0, 8'h02, 0);
      check_val("misaligned resp", 2, 32'(resp));
      check_val("misaligned data", 0, rd);
   endtask
   task t_codes;
      for (int i = 0; i < 16; i++) begin
         bus(1, `OFS_CODE, i);
         check_val("enable", i < 14, 32'(en));
         check_val("invalid", i >= 14, 32'(inv));
         if (i < 14) check_val("code rate", code_rate[i], 32'(rate));
      end
      bus(0, `OFS_STATUS, 0);
      check_val("status", 32'h0000_0021, rd);
      bus(1, `OFS_CODE, 9);
   endtask
   task t_fine;
      bus(1, `OFS_FINE, 50000);
      check_val("mode0 rate", 5000, 32'(rate));
      bus(1, `OFS_MODE, 1);
      check_val("write resp", 0, 32'(resp));
      check_val("fine rate", 50000, 32'(rate));
      check_val("not ready", 1, 32'(nrdy));
      span(0);
      check_val("strobe period", 2000, len);
      check_val("settled", 0, 32'(nrdy));
      bus(1, `OFS_STATUS, 0);
      check_val("status wr resp", 2, 32'(resp));
      bus(0, `OFS_MODE, 0);
      check_val("mode readback", 1, rd);
      bus(1, `OFS_FINE, 1);
      check_val("fine min", 1, 32'(rate));
      bus(1, `OFS_FINE, 65535);
      check_val("fine max", 65535, 32'(rate));
      bus(1, `OFS_FINE, 0);
      check_val("fine off", 0, 32'(en));
      bus(1, `OFS_MODE, 0);
      check_val("back to code", 5000, 32'(rate));
      check_val("enable", 1, 32'(en));
   endtask
   task t_io;
      int n;
      multisample_i <= 1'b1;
      span(1);
      check_val("io 50us", 500, len);
      bus(1, `OFS_CYCLE, 1);
      span(1);
      check_val("io 100us", 1000, len);
      bus(1, `OFS_CYCLE, 2);
      span(1);
      check_val("io reserved", 500, len);
      multisample_i <= 1'b0;
      n = 0;
      repeat (1200) begin
         @(posedge clk_i);
         n += (iou === 1'b1);
      end
      check_val("io idle", 0, n);
   endtask
   // hang guard, sized above the longest expected run
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 95000) begin
         bad_count++;
         report_and_stop;
      end
   end
   // main sequence
   initial begin
      repeat (8) @(posedge clk_i);
      reset_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      t_reset;
      t_codes;
      t_fine;
      t_io;
      report_and_stop;
   end
endmodule
